// *** inc/afs_pkg.sv ***
// Package: addresses, field layout and carriers of the alarm flag bank
package afs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] AFS_ADDR_IRQ_ENABLE   = 16'h00C7;
  localparam logic [15:0] AFS_ADDR_EVENT_FLAGS  = 16'h0200;
  localparam logic [15:0] AFS_ADDR_PHASE_ADJ    = 16'h0204;
  localparam logic [15:0] AFS_ADDR_PLL0_REF     = 16'h0205;
  localparam logic [15:0] AFS_ADDR_IRQ_SUMMARY  = 16'h021A;

  // ----------------------------------------------------------------
  // Event byte field positions
  // ----------------------------------------------------------------
  localparam int AFS_BIT_LOCK_LOSS1   = 7;
  localparam int AFS_BIT_LOCK_LOSS0   = 6;
  localparam int AFS_BIT_HOLDOVER1    = 5;
  localparam int AFS_BIT_HOLDOVER0    = 4;
  localparam int AFS_BIT_SIGNAL_LOSS1 = 1;
  localparam int AFS_BIT_SIGNAL_LOSS0 = 0;
  localparam logic [7:0] AFS_EVENT_MASK = 8'hF3;

  // ----------------------------------------------------------------
  // Feedback-loss, reference and summary byte field positions
  // ----------------------------------------------------------------
  localparam int AFS_BIT_FEEDBACK_LOSS = 4;
  localparam int AFS_REF_LSB           = 0;
  localparam int AFS_REF_WIDTH         = 3;
  localparam int AFS_BIT_IRQ_SUMMARY   = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AFS_RST_FLAGS  = 8'h00;
  localparam logic [7:0] AFS_RST_ENABLE = 8'h00;
  localparam logic [7:0] AFS_RST_RDATA  = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] lock_loss;
    logic [1:0] holdover;
    logic [1:0] signal_loss;
  } afs_event_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } afs_reg_req_t;

endpackage : afs_pkg

// *** hdl/afs_sticky_bank.sv ***
// Module: bank of sticky write-one-to-clear flags
`timescale 1ns/10ps
`default_nettype none
module afs_sticky_bank
  import afs_pkg::*;
#(
  parameter int                 WIDTH     = 8,
  parameter logic [WIDTH-1:0]   RST_VALUE = '0
)
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] set_vec,
  input  wire logic [WIDTH-1:0] clr_vec,
  output var  logic [WIDTH-1:0] flags
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WIDTH < 1)
  begin : g_bad_width
    $error("afs_sticky_bank needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    // Clear only bits written with one; set beats clear
    flags_next = (flags_reg & ~clr_vec) | set_vec;
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_reg <= RST_VALUE;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : afs_sticky_bank
`default_nettype wire

// *** hdl/afs_alarm_flag_bank.sv ***
// Module: alarm event flags, status bytes and interrupt pin
// Function
// - An alarm occurrence sets its matching event flag.
// - A flag stays set after its alarm goes away.
// - Writing one to a flag bit clears only that flag.
// - Byte 0200 bits 7 and 6 hold lock-loss flags of PLL1, PLL0.
// - Bits 5 and 4 hold holdover flags of PLL1, PLL0.
// - Bits 1 and 0 hold signal-loss flags; bits 3, 2 reserved.
// - All six flags reset to zero.
// - Software writes zero to reserved bits; reads are undefined.
// - Byte 0204 bit m is one while output pair m phase-adjusts.
// - Three-bit selected reference of PLL0: none, input 0 or input 1.
// - Byte 0205 feedback-loss bit is one when PLL0 lost feedback.
// - A flag reaches the interrupt pin only with its enable set.
// - Summary bit and low interrupt pin while an enabled flag is set.
`timescale 1ns/10ps
`default_nettype none
module afs_alarm_flag_bank
  import afs_pkg::*;
#(
  parameter int NUM_OUTPUTS = 8
)
(
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  input  wire afs_reg_req_t             reg_req,
  output var  logic [7:0]               reg_rdata,
  output var  logic                     reg_rvalid,
  input  wire afs_event_t               alarm_event,
  input  wire logic [NUM_OUTPUTS-1:0]   phase_adjust_active,
  input  wire logic [AFS_REF_WIDTH-1:0] pll0_selected_reference,
  input  wire logic                     pll0_feedback_loss,
  output var  logic                     irq_out_n_out,
  output var  logic                     irq_out_n_oe
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (NUM_OUTPUTS != 8)
  begin : g_bad_outputs
    $error("afs_alarm_flag_bank serves exactly eight output pairs");
  end

  // ----------------------------------------------------------------
  // Event byte packing
  // ----------------------------------------------------------------
  function automatic logic [7:0] afs_pack_events(input afs_event_t ev);
    logic [7:0] b;
    b = 8'h00;
    b[AFS_BIT_LOCK_LOSS1]   = ev.lock_loss[1];
    b[AFS_BIT_LOCK_LOSS0]   = ev.lock_loss[0];
    b[AFS_BIT_HOLDOVER1]    = ev.holdover[1];
    b[AFS_BIT_HOLDOVER0]    = ev.holdover[0];
    b[AFS_BIT_SIGNAL_LOSS1] = ev.signal_loss[1];
    b[AFS_BIT_SIGNAL_LOSS0] = ev.signal_loss[0];
    return b;
  endfunction : afs_pack_events

  function automatic afs_event_t afs_unpack_events(input logic [7:0] b);
    afs_event_t ev;
    ev.lock_loss   = {b[AFS_BIT_LOCK_LOSS1], b[AFS_BIT_LOCK_LOSS0]};
    ev.holdover    = {b[AFS_BIT_HOLDOVER1], b[AFS_BIT_HOLDOVER0]};
    ev.signal_loss = {b[AFS_BIT_SIGNAL_LOSS1], b[AFS_BIT_SIGNAL_LOSS0]};
    return ev;
  endfunction : afs_unpack_events

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_flags;
  logic wr_enable;

  always_comb
  begin
    wr_flags  = 1'h0;
    wr_enable = 1'h0;
    if (reg_req.wr && (reg_req.addr == AFS_ADDR_EVENT_FLAGS))
    begin
      wr_flags = 1'h1;
    end
    else if (reg_req.wr && (reg_req.addr == AFS_ADDR_IRQ_ENABLE))
    begin
      wr_enable = 1'h1;
    end
    // Status byte writes fall through untouched
    else
    begin
      wr_flags  = 1'h0;
      wr_enable = 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flags;

  always_comb
  begin
    flag_set = afs_pack_events(alarm_event);
    // Reserved positions never clear or store anything
    flag_clr = wr_flags ? (reg_req.wdata & AFS_EVENT_MASK) : 8'h00;
  end

  afs_sticky_bank #(
    .WIDTH     (8),
    .RST_VALUE (AFS_RST_FLAGS)
  ) u_flags (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .set_vec (flag_set),
    .clr_vec (flag_clr),
    .flags   (flags)
  );

  // ----------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------
  logic [7:0] enable_reg;
  logic [7:0] enable_next;
  afs_event_t enable_fields;

  always_comb
  begin
    enable_next = enable_reg;
    if (wr_enable)
    begin
      enable_next = reg_req.wdata & AFS_EVENT_MASK;
    end
    enable_fields = afs_unpack_events(enable_reg);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enable_reg <= AFS_RST_ENABLE;
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin and summary
  // ----------------------------------------------------------------
  logic       pending_reg;
  logic       pending_next;
  logic [7:0] masked_flags;

  always_comb
  begin
    masked_flags = flags & afs_pack_events(enable_fields);
    pending_next = |masked_flags;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pending_reg <= 1'h0;
    end
    else
    begin
      pending_reg <= pending_next;
    end
  end

  // Open-drain: drive low while pending, else release
  logic irq_oe_reg;
  logic irq_oe_next;
  logic irq_out_reg;
  logic irq_out_next;

  always_comb
  begin
    irq_oe_next  = pending_next;
    irq_out_next = 1'h0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_oe_reg  <= 1'h0;
      irq_out_reg <= 1'h0;
    end
    else
    begin
      irq_oe_reg  <= irq_oe_next;
      irq_out_reg <= irq_out_next;
    end
  end

  assign irq_out_n_oe  = irq_oe_reg;
  assign irq_out_n_out = irq_out_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;

  always_comb
  begin
    rdata_next  = rdata_reg;
    rvalid_next = reg_req.rd;
    if (reg_req.rd)
    begin
      // Unmapped and reserved bits read zero
      rdata_next = 8'h00;
      if (reg_req.addr == AFS_ADDR_EVENT_FLAGS)
      begin
        rdata_next = flags & AFS_EVENT_MASK;
      end
      else if (reg_req.addr == AFS_ADDR_IRQ_ENABLE)
      begin
        rdata_next = enable_reg;
      end
      else if (reg_req.addr == AFS_ADDR_PHASE_ADJ)
      begin
        rdata_next = phase_adjust_active;
      end
      else if (reg_req.addr == AFS_ADDR_PLL0_REF)
      begin
        rdata_next[AFS_BIT_FEEDBACK_LOSS] = pll0_feedback_loss;
        rdata_next[AFS_REF_LSB +: AFS_REF_WIDTH] =
          pll0_selected_reference;
      end
      else if (reg_req.addr == AFS_ADDR_IRQ_SUMMARY)
      begin
        rdata_next[AFS_BIT_IRQ_SUMMARY] = pending_reg;
      end
      else
      begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_reg  <= AFS_RST_RDATA;
      rvalid_reg <= 1'h0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

endmodule : afs_alarm_flag_bank
`default_nettype wire

// *** verification/afs_alarm_flag_bank_properties.sv ***
// Checker: timing relations of the alarm flag bank ports
`timescale 1ns/10ps
`default_nettype none
module afs_alarm_flag_bank_properties
  import afs_pkg::*;
#(
  parameter int NUM_OUTPUTS = 8
)
(
  input wire logic                     ref_clk,
  input wire logic                     rstn,
  input wire afs_reg_req_t             reg_req,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     reg_rvalid,
  input wire afs_event_t               alarm_event,
  input wire logic [NUM_OUTPUTS-1:0]   phase_adjust_active,
  input wire logic [AFS_REF_WIDTH-1:0] pll0_selected_reference,
  input wire logic                     pll0_feedback_loss,
  input wire logic                     irq_out_n_out,
  input wire logic                     irq_out_n_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Shadow flags and enables
  // ----------------------------------------------------------------
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] en_reg;
  logic [7:0] en_next;
  logic [7:0] clr;
  always_comb
  begin
    clr = reg_req.wr && reg_req.addr == AFS_ADDR_EVENT_FLAGS ?
          reg_req.wdata : 8'h00;
    sh_next = (sh_reg & ~clr & AFS_EVENT_MASK) | {alarm_event.lock_loss,
              alarm_event.holdover, 2'h0, alarm_event.signal_loss};
    en_next = reg_req.wr && reg_req.addr == AFS_ADDR_IRQ_ENABLE ?
              reg_req.wdata & AFS_EVENT_MASK : en_reg;
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_reg <= 8'h00;
      en_reg <= 8'h00;
    end
    else
    begin
      sh_reg <= sh_next;
      en_reg <= en_next;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_flags;
    reg_req.rd && reg_req.addr == AFS_ADDR_EVENT_FLAGS |=>
      reg_rdata == $past(sh_reg);
  endproperty
  a_flags: assert property (p_flags)
    else $error("event flag byte wrong");
  property p_enable;
    reg_req.rd && reg_req.addr == AFS_ADDR_IRQ_ENABLE |=>
      reg_rdata == $past(en_reg);
  endproperty
  a_enable: assert property (p_enable) else $error("enable byte wrong");
  property p_phase;
    reg_req.rd && reg_req.addr == AFS_ADDR_PHASE_ADJ |=>
      reg_rdata == $past(phase_adjust_active);
  endproperty
  a_phase: assert property (p_phase) else $error("phase byte wrong");
  property p_ref;
    reg_req.rd && reg_req.addr == AFS_ADDR_PLL0_REF |=> reg_rdata ==
      {3'h0, $past(pll0_feedback_loss), 1'h0, $past(pll0_selected_reference)};
  endproperty
  a_ref: assert property (p_ref) else $error("reference byte wrong");
  property p_irq;
    irq_out_n_oe == |$past(sh_reg & en_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pin wrong");
  property p_summary;
    reg_req.rd && reg_req.addr == AFS_ADDR_IRQ_SUMMARY |=>
      reg_rdata == {7'h00, $past(irq_out_n_oe)};
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");
  property p_pin;
    irq_out_n_out == 1'h0;
  endproperty
  a_pin: assert property (p_pin) else $error("pin drives high");
  property p_sticky;
    irq_out_n_oe && !$past(reg_req.wr) |=> irq_out_n_oe;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  cover property (reg_rvalid && reg_rdata != 8'h00);
  cover property ($rose(irq_out_n_oe));
  cover property ((clr & sh_next) != 8'h00);
endmodule : afs_alarm_flag_bank_properties
bind afs_alarm_flag_bank afs_alarm_flag_bank_properties
  #(.NUM_OUTPUTS(NUM_OUTPUTS)) prop_u (.ref_clk, .rstn, .reg_req,
  .reg_rdata, .reg_rvalid, .alarm_event, .phase_adjust_active,
  .pll0_selected_reference, .pll0_feedback_loss, .irq_out_n_out,
  .irq_out_n_oe);
`default_nettype wire

// *** verification/alarm_flag_status_bank_tb.sv ***
// Testbench: alarm flag bank
`timescale 1ns/10ps
`default_nettype none
module alarm_flag_status_bank_tb
  import afs_pkg::*;
;
  typedef struct packed {
    afs_event_t ev;
    logic [7:0] clr;
    logic [7:0] exp;
  } afs_row_t;
  afs_row_t rows [6] = '{'{6'h20, 8'h00, 8'h80}, '{6'h00, 8'h00, 8'h80},
    '{6'h19, 8'h80, 8'h61}, '{6'h06, 8'h40, 8'h33},
    '{6'h01, 8'h01, 8'h33}, '{6'h00, 8'hF3, 8'h00}};
  logic         ref_clk = 1'h0;
  logic         rstn = 1'h0;
  afs_reg_req_t req = '0;
  afs_event_t   ev = '0;
  logic [7:0]   pa = 8'h00;
  logic [2:0]   sel = 3'h0;
  logic         fb = 1'h0;
  logic [7:0]   rdata;
  logic [7:0]   got;
  logic         rvalid;
  logic         oe;
  logic         pin;
  int           num_errors = 0;
  int           tests_run = 0;
  int           cycles = 0;
  afs_alarm_flag_bank dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .alarm_event(ev), .phase_adjust_active(pa),
    .pll0_selected_reference(sel), .pll0_feedback_loss(fb),
    .irq_out_n_out(pin), .irq_out_n_oe(oe));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic tally_and_finish;
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] a);
    tests_run++;
    if (a !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, a);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(negedge ref_clk);
    req.wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge ref_clk);
    req.addr = a;
    req.rd = 1'h1;
    @(negedge ref_clk);
    req.rd = 1'h0;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    got = rdata;
  endtask : rd
  initial
  begin
    repeat (2) @(negedge ref_clk);
    rstn = 1'h1;
    rd(AFS_ADDR_EVENT_FLAGS);
    chk("flags reset", 8'h00, got);
    rd(AFS_ADDR_IRQ_ENABLE);
    chk("enable reset", 8'h00, got);
    for (int i = 0; i < 6; i++)
    begin
      @(negedge ref_clk);
      ev = rows[i].ev;
      req = '{addr: AFS_ADDR_EVENT_FLAGS, wdata: rows[i].clr, wr: 1'h1,
              rd: 1'h0};
      @(negedge ref_clk);
      ev = '0;
      req.wr = 1'h0;
      rd(AFS_ADDR_EVENT_FLAGS);
      chk("flags", rows[i].exp, got);
    end
    for (int i = 0; i < 8; i++)
    begin
      pa = 8'h01 << i;
      sel = i[2:0];
      fb = i[0];
      wr(AFS_ADDR_PLL0_REF, 8'h17);
      rd(AFS_ADDR_PHASE_ADJ);
      chk("phase", 8'h01 << i, got);
      rd(AFS_ADDR_PLL0_REF);
      chk("ref", {3'h0, i[0], 1'h0, i[2:0]}, got);
    end
    rd(AFS_ADDR_IRQ_ENABLE);
    chk("ro write", 8'h00, got);
    ev.signal_loss = 2'h1;
    wr(AFS_ADDR_IRQ_ENABLE, 8'h80);
    ev = '0;
    repeat (2) @(negedge ref_clk);
    chk("oe masked", 8'h00, {7'h00, oe});
    wr(AFS_ADDR_IRQ_ENABLE, 8'h81);
    @(negedge ref_clk);
    chk("oe set", 8'h01, {7'h00, oe});
    chk("pin", 8'h00, {7'h00, pin});
    rd(AFS_ADDR_IRQ_SUMMARY);
    chk("summary", 8'h01, got);
    wr(AFS_ADDR_EVENT_FLAGS, 8'h01);
    @(negedge ref_clk);
    chk("oe clear", 8'h00, {7'h00, oe});
    rd(AFS_ADDR_IRQ_SUMMARY);
    chk("summary clear", 8'h00, got);
    rd(16'h0300);
    chk("unmapped", 8'h00, got);
    ev.lock_loss = 2'h1;
    @(negedge ref_clk);
    ev = '0;
    rstn = 1'h0;
    @(negedge ref_clk);
    rstn = 1'h1;
    rd(AFS_ADDR_EVENT_FLAGS);
    chk("flags rereset", 8'h00, got);
    tally_and_finish();
  end
endmodule : alarm_flag_status_bank_tb
`default_nettype wire
